// file: inc/cesw_pkg.sv
// Constants and types shared by the execution and sleep control core.
package cesw_pkg;
    localparam int INSN_W      = 14;
    localparam int FADDR_W     = 7;
    localparam int PC_W        = 13;
    localparam int REG_DEPTH   = 128;
    localparam int PHASES      = 4;
    localparam logic [1:0]  PHASE_LAST  = 2'h3;
    localparam logic [12:0] RESET_VEC   = 13'h0000;
    localparam logic [12:0] IRQ_VEC     = 13'h0004;
    localparam logic [7:0]  STATUS_ADDR = 8'h03;
    localparam int ST_C   = 0;
    localparam int ST_DC  = 1;
    localparam int ST_Z   = 2;
    localparam int ST_PWRDN   = 3;
    localparam int ST_EXPIRED = 4;
    localparam logic [7:0]  STATUS_RST  = 8'h18;
    localparam logic [15:0] WDOG_RST    = 16'h0000;
    localparam int OFS_ID     = 32'h00;
    localparam int OFS_CTRL   = 32'h04;
    localparam int OFS_STATUS = 32'h08;
    localparam int OFS_WREG   = 32'h0C;
    localparam int OFS_PC     = 32'h10;
    localparam int OFS_WDOG   = 32'h14;
    localparam int CTRL_WDTE  = 0;
    localparam int CTRL_GIRQ  = 1;
    localparam int CTRL_RUN   = 2;
    // The identity value is arbitrary; it only shows that the block is there.
    localparam logic [31:0] ID_VALUE = 32'h0000_5A01;
    localparam logic [4:0]  OPC_ADD_LIT  = 5'h1F;
    localparam logic [5:0]  OPC_ADD_REG  = 6'h07;
    localparam logic [5:0]  OPC_AND_LIT  = 6'h39;
    localparam logic [5:0]  OPC_AND_REG  = 6'h05;
    localparam logic [3:0]  OPC_BIT_CLR  = 4'h4;
    localparam logic [3:0]  OPC_BIT_SET  = 4'h5;
    localparam logic [3:0]  OPC_SKIP_CLR = 4'h6;
    localparam logic [3:0]  OPC_SKIP_SET = 4'h7;
    localparam logic [2:0]  OPC_GOTO  = 3'h5;
    localparam logic [13:0] OPC_SLEEP = 14'h0063;
    localparam logic [13:0] OPC_CLRWDT = 14'h0064;
    typedef enum logic [3:0] {
        CESW_NOP, CESW_ADDL, CESW_ADDF, CESW_ANDL, CESW_ANDF,
        CESW_BCLR, CESW_BSET, CESW_SKC, CESW_SKS, CESW_JUMP,
        CESW_SLEEP, CESW_CLRWDT
    } cesw_op_t;
endpackage : cesw_pkg

// file: hw/cesw_core.sv
// Execution core: decode, read-modify-write, sleep and wake control.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module cesw_core (
    input  wire logic                ref_clk_i,
    input  wire logic                nrst_i,
    input  wire logic                clk_en_i,
    input  wire logic                ext_reset_pin_n_i,
    input  wire logic                ext_irq_pin_i,
    input  wire logic                ext_irq_en_i,
    input  wire logic                port_change_i,
    input  wire logic                port_change_en_i,
    input  wire logic                periph_irq_i,
    input  wire logic                periph_irq_en_i,
    input  wire logic                watchdog_timeout_i,
    input  wire logic [13:0]         insn_i,
    output logic      [12:0]         pmem_addr_o,
    output logic                     osc_run_o,
    output logic                     io_hold_o,
    output logic                     watchdog_clear_o,
    output logic                     core_reset_o,
    input  wire logic [5:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest
);
    ////////////////////////////////////////////////////////////////////////
    // Every outside source passes two flops before any logic reads it.
    logic        rpin_s1_q;
    logic        rpin_s2_q;
    logic        int_s1_q;
    logic        int_s2_q;
    logic        chg_s1_q;
    logic        chg_s2_q;
    logic        per_s1_q;
    logic        per_s2_q;
    logic        wdog_s1_q;
    logic        wdog_s2_q;
    // The reset pin idles high, so its flops start high to avoid a false
    // core reset in the first cycles after the synchronous reset lifts.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rpin_s1_q <= 1'b1;
            rpin_s2_q <= 1'b1;
            int_s1_q  <= 1'b0;
            int_s2_q  <= 1'b0;
            chg_s1_q  <= 1'b0;
            chg_s2_q  <= 1'b0;
            per_s1_q  <= 1'b0;
            per_s2_q  <= 1'b0;
            wdog_s1_q <= 1'b0;
            wdog_s2_q <= 1'b0;
        end else if (clk_en_i) begin
            rpin_s1_q <= ext_reset_pin_n_i;
            rpin_s2_q <= rpin_s1_q;
            int_s1_q  <= ext_irq_pin_i;
            int_s2_q  <= int_s1_q;
            chg_s1_q  <= port_change_i;
            chg_s2_q  <= chg_s1_q;
            per_s1_q  <= periph_irq_i;
            per_s2_q  <= per_s1_q;
            wdog_s1_q <= watchdog_timeout_i;
            wdog_s2_q <= wdog_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Whole-word controls are matched first, so that no shorter opcode
    // field can claim them; unknown words fall through to a no-operation.
    function automatic cesw_pkg::cesw_op_t decode(input logic [13:0] w);
        cesw_pkg::cesw_op_t op;
        op = cesw_pkg::CESW_NOP;
        if (w == cesw_pkg::OPC_SLEEP)
            op = cesw_pkg::CESW_SLEEP;
        else if (w == cesw_pkg::OPC_CLRWDT)
            op = cesw_pkg::CESW_CLRWDT;
        else if (w[13:9] == cesw_pkg::OPC_ADD_LIT)
            op = cesw_pkg::CESW_ADDL;
        else if (w[13:8] == cesw_pkg::OPC_AND_LIT)
            op = cesw_pkg::CESW_ANDL;
        else if (w[13:8] == cesw_pkg::OPC_ADD_REG)
            op = cesw_pkg::CESW_ADDF;
        else if (w[13:8] == cesw_pkg::OPC_AND_REG)
            op = cesw_pkg::CESW_ANDF;
        else if (w[13:10] == cesw_pkg::OPC_BIT_CLR)
            op = cesw_pkg::CESW_BCLR;
        else if (w[13:10] == cesw_pkg::OPC_BIT_SET)
            op = cesw_pkg::CESW_BSET;
        else if (w[13:10] == cesw_pkg::OPC_SKIP_CLR)
            op = cesw_pkg::CESW_SKC;
        else if (w[13:10] == cesw_pkg::OPC_SKIP_SET)
            op = cesw_pkg::CESW_SKS;
        else if (w[13:11] == cesw_pkg::OPC_GOTO)
            op = cesw_pkg::CESW_JUMP;
        return op;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  regs_q [cesw_pkg::REG_DEPTH];
    // Core state and the decoded view of the current instruction.
    logic [7:0]  w_q;
    logic [7:0]  status_q;
    logic [7:0]  rd_val;
    logic [7:0]  result;
    logic [12:0] pc_q;
    logic [13:0] ir_q;
    logic [1:0]  phase_q;
    logic        sleep_q;
    logic        flush_q;
    logic        vector_q;
    logic        wdte_q;
    logic        girq_en_q;
    logic        run_q;
    logic        c_new;
    logic        dc_new;
    logic        z_new;
    logic        take_alt;
    logic        sleep_now;
    logic        wake_any;
    logic        wake_irq;
    logic        wake_wdt;
    logic        pending;
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic [6:0]  faddr;
    logic [2:0]  bsel;
    cesw_pkg::cesw_op_t op;

    assign op    = decode(ir_q);
    assign faddr = ir_q[6:0];
    assign bsel  = ir_q[9:7];
    assign rd_val = (faddr == cesw_pkg::STATUS_ADDR[6:0]) ? status_q
                                                          : regs_q[faddr];
    assign sum9  = {1'b0, w_q} +
        {1'b0, (op == cesw_pkg::CESW_ADDL) ? ir_q[7:0] : rd_val};
    assign sum5  = {1'b0, w_q[3:0]} +
        {1'b0, (op == cesw_pkg::CESW_ADDL) ? ir_q[3:0] : rd_val[3:0]};
    assign pending = (int_s2_q & ext_irq_en_i) |
                     (chg_s2_q & port_change_en_i) |
                     (per_s2_q & periph_irq_en_i);
    assign wake_irq  = pending;
    assign wake_wdt  = wdte_q & wdog_s2_q;
    assign wake_any  = wake_irq | wake_wdt;
    assign sleep_now = (op == cesw_pkg::CESW_SLEEP) && !flush_q;

    always_comb begin
        result = rd_val;
        c_new  = status_q[cesw_pkg::ST_C];
        dc_new = status_q[cesw_pkg::ST_DC];
        z_new  = status_q[cesw_pkg::ST_Z];
        take_alt = 1'b0;
        case (op)
            cesw_pkg::CESW_ADDL, cesw_pkg::CESW_ADDF: begin
                result = sum9[7:0];
                c_new  = sum9[8];
                dc_new = sum5[4];
                z_new  = (sum9[7:0] == 8'h00);
            end
            cesw_pkg::CESW_ANDL: begin
                result = w_q & ir_q[7:0];
                z_new  = (result == 8'h00);
            end
            cesw_pkg::CESW_ANDF: begin
                result = w_q & rd_val;
                z_new  = (result == 8'h00);
            end
            cesw_pkg::CESW_BCLR: result[bsel] = 1'b0;
            cesw_pkg::CESW_BSET: result[bsel] = 1'b1;
            cesw_pkg::CESW_SKC:  take_alt = ~rd_val[bsel];
            cesw_pkg::CESW_SKS:  take_alt = rd_val[bsel];
            cesw_pkg::CESW_JUMP: take_alt = 1'b1;
            default: result = rd_val;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Execution happens on the last phase; the first three model the
    // read, modify and fetch steps of a four-period cycle.
    logic exec;
    logic reset_req;
    assign exec = clk_en_i && run_q && !sleep_q &&
                  (phase_q == cesw_pkg::PHASE_LAST);
    assign reset_req = !rpin_s2_q || (wdog_s2_q && wdte_q && !sleep_q);

    // The phase counter restarts on reset and sleep, so the first cycle
    // after either always runs a full four clocks.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i)
            phase_q <= 2'h0;
        else if (clk_en_i && (reset_req || sleep_q))
            phase_q <= 2'h0;
        else if (clk_en_i && run_q)
            phase_q <= phase_q + 2'h1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pc_q     <= cesw_pkg::RESET_VEC;
            ir_q     <= 14'h0000;
            flush_q  <= 1'b0;
            vector_q <= 1'b0;
        end else if (clk_en_i && reset_req) begin
            pc_q     <= cesw_pkg::RESET_VEC;
            ir_q     <= 14'h0000;
            flush_q  <= 1'b1;
            vector_q <= 1'b0;
            // The prefetched word still runs first; the vector follows it.
            // Software that must not run it puts a no-operation after sleep.
        end else if (clk_en_i && sleep_q && wake_any) begin
            vector_q <= girq_en_q && wake_irq;
        end else if (exec) begin
            ir_q    <= insn_i;
            flush_q <= !flush_q && take_alt;
            if (vector_q) begin
                pc_q     <= cesw_pkg::IRQ_VEC;
                flush_q  <= 1'b1;
                vector_q <= 1'b0;
            end else if (!flush_q && op == cesw_pkg::CESW_JUMP)
                pc_q <= {pc_q[12:11], ir_q[10:0]};
            else
                pc_q <= pc_q + 13'h0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i)
            w_q <= 8'h00;
        else if (exec && !flush_q) begin
            if (op == cesw_pkg::CESW_ADDL || op == cesw_pkg::CESW_ANDL)
                w_q <= result;
            else if ((op == cesw_pkg::CESW_ADDF ||
                      op == cesw_pkg::CESW_ANDF) && !ir_q[7])
                w_q <= result;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        // The array has no reset; software must write a location first.
        // This saves a wide reset tree on what is plain data storage.
        if (exec && !flush_q && faddr != cesw_pkg::STATUS_ADDR[6:0]) begin
            if (((op == cesw_pkg::CESW_ADDF || op == cesw_pkg::CESW_ANDF)
                 && ir_q[7]) || op == cesw_pkg::CESW_BCLR ||
                op == cesw_pkg::CESW_BSET)
                regs_q[faddr] <= result;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i)
            status_q <= cesw_pkg::STATUS_RST;
        // A watchdog wake and an executed instruction never meet, since
        // execution needs the core awake.
        else if (clk_en_i && sleep_q && wake_wdt)
            status_q[cesw_pkg::ST_EXPIRED] <= 1'b0;
        else if (exec && !flush_q) begin
            status_q[cesw_pkg::ST_C]  <= c_new;
            status_q[cesw_pkg::ST_DC] <= dc_new;
            status_q[cesw_pkg::ST_Z]  <= z_new;
            if (sleep_now) begin
                status_q[cesw_pkg::ST_PWRDN]   <= 1'b0;
                status_q[cesw_pkg::ST_EXPIRED] <= 1'b1;
            end
            if (faddr == cesw_pkg::STATUS_ADDR[6:0] &&
                (op == cesw_pkg::CESW_BCLR || op == cesw_pkg::CESW_BSET) &&
                bsel > 3'h4)
                status_q[bsel] <= result[bsel];
        end
    end

    // Sleep is entered after the instruction completes, so a wake that is
    // already pending ends it one clock later.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i)
            sleep_q <= 1'b0;
        else if (clk_en_i && reset_req)
            sleep_q <= 1'b0;
        else if (clk_en_i && sleep_q && wake_any)
            sleep_q <= 1'b0;
        else if (exec && sleep_now)
            sleep_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            osc_run_o        <= 1'b1;
            io_hold_o        <= 1'b0;
            watchdog_clear_o <= 1'b0;
            core_reset_o     <= 1'b1;
            pmem_addr_o      <= cesw_pkg::RESET_VEC;
        end else if (clk_en_i) begin
            // A pending wake does not keep the oscillator from stopping: it stops
            // for the one clock of sleep entry and runs again on the next.
            osc_run_o   <= !(sleep_q && !wake_any) &&
                           !(exec && sleep_now);
            io_hold_o   <= (sleep_q && !wake_any) || (exec && sleep_now);
            // Pin is never driven; core_reset_o carries both the pin reset and the watchdog reset.
            core_reset_o <= reset_req;
            watchdog_clear_o <= (exec && (sleep_now ||
                op == cesw_pkg::CESW_CLRWDT) && !flush_q) ||
                (sleep_q && wake_any);
            pmem_addr_o <= pc_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus: every access takes one wait state, reads and writes
    // alike, so a master never has to know which one is faster.
    logic        ack_q;
    logic [31:0] rdata;
    always_comb begin
        case ({26'h0, avs_address} << 2)
            cesw_pkg::OFS_ID:     rdata = cesw_pkg::ID_VALUE;
            cesw_pkg::OFS_CTRL:   rdata = {29'h0, run_q, girq_en_q, wdte_q};
            cesw_pkg::OFS_STATUS: rdata = {23'h0, sleep_q, status_q};
            cesw_pkg::OFS_WREG:   rdata = {24'h0, w_q};
            cesw_pkg::OFS_PC:     rdata = {19'h0, pc_q};
            default:              rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ack_q        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            wdte_q       <= 1'b0;
            girq_en_q    <= 1'b0;
            run_q        <= 1'b0;
        end else if (clk_en_i) begin
            ack_q <= (avs_read || avs_write) && !ack_q;
            if (avs_read && !ack_q)
                avs_readdata <= rdata;
            // A write lands on the edge that sees waitrequest low, so a
            // master that drops its request early leaves the core alone.
            if (avs_write && ack_q && avs_byteenable[0] &&
                ({26'h0, avs_address} << 2) == cesw_pkg::OFS_CTRL) begin
                wdte_q    <= avs_writedata[cesw_pkg::CTRL_WDTE];
                girq_en_q <= avs_writedata[cesw_pkg::CTRL_GIRQ];
                run_q  <= avs_writedata[cesw_pkg::CTRL_RUN];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i)
            avs_waitrequest <= 1'b1;
        else if (clk_en_i)
            // Low for exactly one cycle; it rises again while the master
            // is still dropping its request.
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
        else
            avs_waitrequest <= 1'b1;
    end
endmodule : cesw_core

// file: tb/cesw_pmem.sv
// Program memory model feeding instruction words to the core.
`timescale 1ns/1ps
module cesw_pmem (
    input  wire logic [12:0] addr_i,
    output logic      [13:0] word_o
);
    // Only 64 words are backed; higher addresses alias, never used here.
    logic [13:0] mem [0:63];

    assign word_o = mem[addr_i[5:0]];
endmodule : cesw_pmem

// file: tb/cesw_core_chk.sv
// Concurrent checks on the ports of the execution and sleep core.
`timescale 1ns/1ps
module cesw_chk (
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    input wire logic        ext_reset_pin_n_i,
    input wire logic        ext_irq_pin_i,
    input wire logic        ext_irq_en_i,
    input wire logic        port_change_i,
    input wire logic        port_change_en_i,
    input wire logic        periph_irq_i,
    input wire logic        periph_irq_en_i,
    input wire logic        watchdog_timeout_i,
    input wire logic [12:0] pmem_addr_o,
    input wire logic        osc_run_o,
    input wire logic        io_hold_o,
    input wire logic        watchdog_clear_o,
    input wire logic        core_reset_o,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////
    // Recent wake cause; sync delays make a same-cycle test too strict.
    logic [3:0] cause_q;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i)
            cause_q <= 4'h0;
        else if (!ext_reset_pin_n_i || watchdog_timeout_i
                 || (ext_irq_pin_i && ext_irq_en_i)
                 || (port_change_i && port_change_en_i)
                 || (periph_irq_i && periph_irq_en_i))
            cause_q <= 4'hA;
        else if (cause_q != 4'h0)
            cause_q <= cause_q - 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_enter; $fell(osc_run_o) |-> io_hold_o && watchdog_clear_o;
    endproperty
    a_enter: assert property (p_enter) else $error("sleep entry bad");
    property p_hold; osc_run_o ^ io_hold_o; endproperty
    a_hold: assert property (p_hold) else $error("hold mismatch");
    property p_wclr; $rose(osc_run_o) && !core_reset_o |-> watchdog_clear_o
        || $past(watchdog_clear_o) || $past(watchdog_clear_o, 2); endproperty
    a_wclr: assert property (p_wclr) else $error("no wake clear");
    property p_pin; !ext_reset_pin_n_i [*4] |-> ##[0:2] core_reset_o;
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset missed");
    property p_wdr; (watchdog_timeout_i && !io_hold_o) [*3]
        |-> ##[0:3] core_reset_o; endproperty
    a_wdr: assert property (p_wdr) else $error("no internal reset");
    property p_cyc; $changed(pmem_addr_o) && !core_reset_o
        |=> ($stable(pmem_addr_o) || core_reset_o) [*3]; endproperty
    a_cyc: assert property (p_cyc) else $error("fetch too early");
    property p_irq; io_hold_o && periph_irq_i && periph_irq_en_i
        |-> ##[1:8] !io_hold_o; endproperty
    a_irq: assert property (p_irq) else $error("irq no wake");
    property p_cause; $fell(io_hold_o) |-> cause_q != 4'h0; endproperty
    a_cause: assert property (p_cause) else $error("wake uncaused");
    property p_pend; $rose(io_hold_o) && periph_irq_i && periph_irq_en_i
        && $past(periph_irq_i, 4) |-> ##[1:2] !io_hold_o; endproperty
    a_pend: assert property (p_pend) else $error("pending no wake");
    property p_bus; (avs_read || avs_write) && avs_waitrequest
        |-> ##[0:2] !avs_waitrequest; endproperty
    a_bus: assert property (p_bus) else $error("bus answer late");
endmodule : cesw_chk

bind cesw_core cesw_chk u_chk (.ref_clk_i, .nrst_i, .ext_reset_pin_n_i,
    .ext_irq_pin_i, .ext_irq_en_i, .port_change_i, .port_change_en_i,
    .periph_irq_i, .periph_irq_en_i, .watchdog_timeout_i, .pmem_addr_o,
    .osc_run_o, .io_hold_o, .watchdog_clear_o, .core_reset_o, .avs_read,
    .avs_write, .avs_waitrequest);

// file: tb/core_exec_sleep_wake_bench.sv
// Self-checking bench for the execution and sleep core.
`timescale 1ns/1ps
module core_exec_sleep_wake_bench;
    logic        ref_clk_i = 1'b0, nrst_i = 1'b0, clk_en_i = 1'b1;
    logic        ext_reset_pin_n_i = 1'b1, ext_irq_pin_i = 1'b0;
    logic        ext_irq_en_i = 1'b1, port_change_i = 1'b0;
    logic        port_change_en_i = 1'b0, periph_irq_i = 1'b0;
    logic        periph_irq_en_i = 1'b1, watchdog_timeout_i = 1'b0;
    logic [13:0] insn_i;
    logic [12:0] pmem_addr_o;
    logic        osc_run_o, io_hold_o, watchdog_clear_o, core_reset_o;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0]  avs_byteenable = 4'hF;
    int          seed = 33938, errors = 0, n_tests = 0;
    logic [7:0]  a, v, s, p;
    logic [6:0]  f;
    logic [2:0]  bt, fl;
    logic [10:0] r;
    logic        cls;

    cesw_core dut (.ref_clk_i, .nrst_i, .clk_en_i, .ext_reset_pin_n_i,
        .ext_irq_pin_i, .ext_irq_en_i, .port_change_i, .port_change_en_i,
        .periph_irq_i, .periph_irq_en_i, .watchdog_timeout_i, .insn_i,
        .pmem_addr_o, .osc_run_o, .io_hold_o, .watchdog_clear_o,
        .core_reset_o, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest);
    cesw_pmem pm (.addr_i(pmem_addr_o), .word_o(insn_i));

    always #12.5 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    // Bounded wait on io_hold_o (sel 0) or core_reset_o (sel 1).
    task automatic wait_for(input int sel, input logic lvl);
        int n;
        for (n = 0; n < 3000; n++) begin
            if ((sel == 1 ? core_reset_o : io_hold_o) === lvl)
                break;
            @(posedge ref_clk_i);
        end
        if (n == 3000) begin
            errors++;
            give_verdict();
        end
    endtask : wait_for

    // One edge first, so a release and a new request never share a step.
    task automatic bus(input logic wr, input int ofs, input logic [31:0] wd);
        int n;
        @(posedge ref_clk_i);
        avs_address <= 6'(ofs >> 2);
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk_i);
            if (avs_waitrequest === 1'b0)
                break;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n == 50) begin
            errors++;
            give_verdict();
        end
    endtask : bus

    task automatic restart;
        nrst_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
    endtask : restart

    function automatic logic [10:0] addf(input logic [7:0] x, y);
        logic [8:0] t;
        logic [4:0] h;
        t = {1'b0, x} + {1'b0, y};
        h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
        return {t[7:0] == 8'h00, h[4], t[8], t[7:0]};
    endfunction : addf
    ////////////////////////////////////////////////////////////////////////
    initial begin
        restart();
        bus(1'b0, cesw_pkg::OFS_ID, 32'h0);
        check(rd, cesw_pkg::ID_VALUE);
        bus(1'b0, cesw_pkg::OFS_STATUS, 32'h0);
        check(rd, {24'h0, cesw_pkg::STATUS_RST});
        bus(1'b0, 32'hFC, 32'h0);
        check(rd, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 8'h01 : (i == 1) ? 8'h08 : 8'($random(seed));
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h08 : 8'($random(seed));
            f = (i == 0) ? 7'h7F : 7'h20 + 7'({$random(seed)} % 96);
            bt = 3'($random(seed));
            cls = i[0];
            for (int j = 0; j < 64; j++)
                pm.mem[j] = 14'h0000;
            for (int j = 0; j < 8; j++)
                pm.mem[j] = {v[j] ? cesw_pkg::OPC_BIT_SET
                                  : cesw_pkg::OPC_BIT_CLR, 3'(j), f};
            pm.mem[8] = {cesw_pkg::OPC_AND_LIT, 8'h00};
            pm.mem[9] = {cesw_pkg::OPC_ADD_LIT, 1'b0, a};
            pm.mem[10] = {cesw_pkg::OPC_ADD_REG, 1'b0, f};
            pm.mem[11] = {cesw_pkg::OPC_AND_REG, 1'b1, f};
            pm.mem[12] = {cls ? cesw_pkg::OPC_SKIP_CLR
                              : cesw_pkg::OPC_SKIP_SET, bt, f};
            pm.mem[13] = {cesw_pkg::OPC_ADD_LIT, 1'b0, 8'h01};
            pm.mem[14] = cesw_pkg::OPC_SLEEP;
            r = addf(a, v);
            s = r[7:0];
            fl = r[10:8];
            p = s & v;
            fl[2] = (p == 8'h00);
            if (p[bt] == cls) begin
                r = addf(s, 8'h01);
                s = r[7:0];
                fl = r[10:8];
            end
            restart();
            bus(1'b1, cesw_pkg::OFS_CTRL, 32'h4);
            wait_for(0, 1'b1);
            check(osc_run_o, 1'b0);
            check(pmem_addr_o, 13'h00F);
            bus(1'b0, cesw_pkg::OFS_STATUS, 32'h0);
            check(rd, {23'h0, 1'b1, 3'h0, 2'b10, fl});
            bus(1'b0, cesw_pkg::OFS_WREG, 32'h0);
            check(rd, {24'h0, s});
            $display("arithmetic pass %0d done", i);
        end
        for (int j = 0; j < 64; j++)
            pm.mem[j] = 14'h0000;
        pm.mem[0] = {cesw_pkg::OPC_AND_LIT, 8'h00};
        pm.mem[1] = cesw_pkg::OPC_SLEEP;
        pm.mem[2] = {cesw_pkg::OPC_ADD_LIT, 1'b0, 8'h10};
        pm.mem[3] = cesw_pkg::OPC_SLEEP;
        pm.mem[4] = {cesw_pkg::OPC_GOTO, 11'h004};
        for (int g = 0; g < 3; g++) begin
            restart();
            periph_irq_i <= (g == 2);
            bus(1'b1, cesw_pkg::OFS_CTRL, {29'h0, 1'b1, g == 1, 1'b1});
            if (g == 2) begin
                repeat (200) @(posedge ref_clk_i);
                check(io_hold_o, 1'b0);
            end else begin
                wait_for(0, 1'b1);
                port_change_i <= 1'b1;
                repeat (30) @(posedge ref_clk_i);
                check(io_hold_o, 1'b1);
                port_change_i <= 1'b0;
                ext_irq_pin_i <= 1'b1;
                wait_for(0, 1'b0);
                ext_irq_pin_i <= 1'b0;
                repeat (60) @(posedge ref_clk_i);
                check(io_hold_o, g == 0);
            end
            periph_irq_i <= 1'b0;
            bus(1'b0, cesw_pkg::OFS_WREG, 32'h0);
            check(rd, 32'h10);
            if (g == 0) begin
                check(pmem_addr_o, 13'h005);
                watchdog_timeout_i <= 1'b1;
                repeat (1) @(posedge ref_clk_i);
                watchdog_timeout_i <= 1'b0;
                wait_for(0, 1'b0);
                repeat (40) @(posedge ref_clk_i);
                bus(1'b0, cesw_pkg::OFS_STATUS, 32'h0);
                check(rd, 32'h0);
                watchdog_timeout_i <= 1'b1;
                wait_for(1, 1'b1);
                watchdog_timeout_i <= 1'b0;
                ext_reset_pin_n_i <= 1'b0;
                repeat (6) @(posedge ref_clk_i);
                check(core_reset_o, 1'b1);
                ext_reset_pin_n_i <= 1'b1;
            end
            $display("wake pass %0d done", g);
        end
        give_verdict();
    end
endmodule : core_exec_sleep_wake_bench
